// ### bench/cdes_board.sv
// Board model: reference oscillators and the gate and power-down pin drivers
`timescale 1ns/1ps
`default_nettype none
module cdes_board (
   input wire logic clk,
   input wire logic oscOn,
   input wire logic gateReq,
   input wire logic pdnReq,
   output logic internalRefClk,
   output logic externalRefClk,
   output logic gatePin,
   output logic powerDownSelectPin
);
   logic [2:0] intCnt = 3'h0;
   logic [2:0] extCnt = 3'h2;
   initial internalRefClk = 1'b0;
   initial externalRefClk = 1'b0;
   initial gatePin = 1'b0;
   initial powerDownSelectPin = 1'b1;

   // Internal oscillator, half period 4 clk; it dies with its power enable
   // oscillator stops when disabled
   always @(posedge clk)
   begin
      intCnt <= (!oscOn || intCnt == 3'h3) ? 3'h0 : intCnt + 3'h1;
      if (!oscOn) internalRefClk <= 1'b0;
      else if (intCnt == 3'h3) internalRefClk <= ~internalRefClk;
   end

   // External reference runs free, half period 6 clk, other phase
   always @(posedge clk)
   begin
      extCnt <= (extCnt == 3'h5) ? 3'h0 : extCnt + 3'h1;
      if (extCnt == 3'h5) externalRefClk <= ~externalRefClk;
   end

   // Pins follow the board requests one clk later
   always @(posedge clk)
   begin
      gatePin <= gateReq;
      powerDownSelectPin <= pdnReq;
   end
endmodule : cdes_board
`default_nettype wire

// ### bench/clock_divider_enable_sequencer_bench.sv
// Self-checking bench for the clock divider and enable sequencer
`timescale 1ns/1ps
`default_nettype none
module clock_divider_enable_sequencer_bench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic gateReq = 1'b0;
   logic pdnReq = 1'b1;
   logic measure = 1'b0;
   logic seenRise = 1'b0;
   logic prevPin = 1'b0;
   logic prevRef = 1'b0;
   int refRises = 0;
   cdes_pkg::cdes_cfg_t cfg = cdes_pkg::CFG_DEFAULT;
   cdes_pkg::cdes_cfg_t c;
   logic internalRefClk, externalRefClk, gatePin, powerDownSelectPin;
   logic referenceClockPin, referenceClockOe, dividedClockPin, dividedClockOe;
   logic internalOscEnable, externalBufferEnable, stabilizing;
   logic [31:0] lfsrState = 32'h89ef;
   int failures = 0;
   int samples_checked = 0;
   int sinceRise = 0;
   int hiRun = 0;
   int riseCount = 0;
   int expPeriod = 0;
   int expHigh = 0;

   initial
   begin
      forever #5 clk = ~clk;
   end

   cdes_board u_cdes_board (.clk, .oscOn(internalOscEnable), .gateReq, .pdnReq,
      .internalRefClk, .externalRefClk, .gatePin, .powerDownSelectPin);
   cdes_core u_cdes_core (.clk, .reset_n, .internalRefClk, .externalRefClk, .gatePin,
      .powerDownSelectPin, .storedConfig(cfg), .referenceClockPin, .referenceClockOe,
      .dividedClockPin, .dividedClockOe, .internalOscEnable, .externalBufferEnable,
      .stabilizing);

   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext

   // Master period in clk for the internal reference and the chosen prescaler
   function automatic int masterPer(input cdes_pkg::cdes_cfg_t k);
      if (k.prescalerBypass) return 8;
      return k.prescalerRatio ? 16 : 32;
   endfunction : masterPer

   task automatic results();
      $display("Checks made %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // Bounded wait for one status output to reach a level
   task automatic waitFor(input int sel, input logic lvl, input int bound);
      logic v;
      for (int i = 0; i < bound; i++)
      begin
         case (sel)
            0: v = dividedClockOe;
            2: v = internalOscEnable;
            default: v = stabilizing;
         endcase
         if (v === lvl) return;
         @(posedge clk);
      end
      chk("wait bound", 32'h1, 32'h0);
      results();
   endtask : waitFor

   // Pulse monitor: every period and every high width seen while measuring
   always @(posedge clk)
   begin
      prevPin <= dividedClockPin;
      prevRef <= referenceClockPin;
      if (prevRef === 1'b0 && referenceClockPin === 1'b1) refRises <= refRises + 1;
      sinceRise <= sinceRise + 1;
      hiRun <= (dividedClockPin === 1'b1) ? hiRun + 1 : 0;
      if (!measure) seenRise <= 1'b0;
      if (prevPin === 1'b0 && dividedClockPin === 1'b1)
      begin
         riseCount <= riseCount + 1;
         sinceRise <= 1;
         seenRise <= measure;
         if (measure && seenRise) chk("period", expPeriod, sinceRise);
      end
      if (measure && prevPin === 1'b1 && dividedClockPin === 1'b0)
         chk("high width", expHigh, hiRun);
   end

   // Power down, then up, so that the new stored settings are loaded
   task automatic powerCycle(input cdes_pkg::cdes_cfg_t k);
      int t;
      cfg <= k;
      pdnReq <= 1'b0;
      waitFor(0, 1'b0, 9000);
      chk("divided low at float", 32'h0, dividedClockPin);
      waitFor(2, 1'b0, 200);
      chk("tap off before osc", 32'h0, referenceClockOe);
      chk("buffer off", 32'h0, externalBufferEnable);
      pdnReq <= 1'b1;
      waitFor(3, 1'b1, 20);
      for (t = 0; stabilizing === 1'b1 && t < 12000; t++) @(posedge clk);
      chk("stabilise length", 32'h1, t > 8150 && t < 8300);
      waitFor(0, 1'b1, 5);
      chk("tap enable", !k.referenceTapDisable, referenceClockOe);
      // Tap must toggle with the gate low, or stay quiet when disabled
      t = refRises;
      repeat (80) @(posedge clk);
      chk("tap toggles", !k.referenceTapDisable, refRises != t);
   endtask : powerCycle

   // Gate the output on, let it run, gate it off at a random moment
   task automatic gateRun(input int mp, input int dn, input int per);
      int r;
      int n;
      expPeriod = mp * dn;
      expHigh = (dn == 1) ? mp / 2 : (dn / 2) * mp;
      measure <= 1'b1;
      gateReq <= 1'b1;
      r = riseCount;
      for (n = 0; riseCount == r && n < 300; n++) @(posedge clk);
      chk("first edge delay", 32'h1, n <= 2 * mp + 8);
      lfsrState = lfsrNext(lfsrState);
      repeat (per * expPeriod + int'(lfsrState[3:0])) @(posedge clk);
      gateReq <= 1'b0;
      repeat (2 * expPeriod + 20) @(posedge clk);
      r = riseCount;
      repeat (expPeriod + 10) @(posedge clk);
      chk("no pulse after gate off", r, riseCount);
      chk("divided parked low", 32'h0, dividedClockPin);
      measure <= 1'b0;
   endtask : gateRun

   initial
   begin
      repeat (8) @(posedge clk);
      chk("osc off in reset", 32'h0, internalOscEnable);
      chk("stabilising in reset", 32'h1, stabilizing);
      reset_n <= 1'b1;
      @(posedge clk);
      waitFor(3, 1'b0, 12000);
      chk("shipped tap floats", 32'h0, referenceClockOe);
      gateRun(8, 2, 3);
      // Settings table: divisor 1 and 511, both prescaler ratios, bypass, select mode
      for (int k = 0; k < 6; k++)
      begin
         c = cdes_pkg::CFG_DEFAULT;
         lfsrState = lfsrNext(lfsrState);
         c.divisorWord = {4'h0, lfsrState[4:0]};
         c.referenceTapDisable = k[0];
         c.prescalerBypass = (k != 1 && k != 2);
         c.prescalerRatio = (k == 2);
         if (k == 1) c.divisorWord = 9'h001;
         if (k == 3) c.divisorWord = 9'h1ff;
         c.bypassDivisor = (k >= 4);
         c.pinFunction = (k != 5);
         powerCycle(c);
         gateRun(masterPer(c), c.bypassDivisor ? 1 : int'(c.divisorWord) + 2, 2);
      end
      // Select mode: pin low picks the external reference, no power-down
      pdnReq <= 1'b0;
      repeat (100) @(posedge clk);
      chk("select keeps output", 32'h1, dividedClockOe);
      gateRun(12, 1, 3);
      pdnReq <= 1'b1;
      repeat (100) @(posedge clk);
      gateRun(8, 1, 3);
      results();
   end
endmodule : clock_divider_enable_sequencer_bench
`default_nettype wire

// ### hdl/cdes_core.sv
// Reference mux, prescaler, divider and enabling sequencer
// What this block does
// [RL1] Divide master clock by divisor plus two
// [RL2] Pin function bit picks select or power-down
// [RL3] Tap disable bit floats reference pin
// [RL4] Gate ignores tap; power-down turns tap off
// [RL5] Gate sampled on master rise, start 1-2 periods
// [RL6] Missed gate edge completes one cycle later
// [RL7] Falling gate never truncates a high pulse
// [RL8] Missed disable while low gives extra pulse
// [RL9] Divide-by-one disable gives one or two pulses
// [RL10] Internal-to-external: detect on falling, hold low
// [RL11] Route external only once it is low
// [RL12] External-to-internal is level triggered
// [RL13] Hold low until internal fall, pass rise
// [RL14] Divided pin shares glitch-free switching
// [RL15] High power-down pin runs, low starts sequence
// [RL16] Gate off, float divided, stop master, float tap
// [RL17] Finally disable oscillator and input buffer
// [RL18] Release: enable, maximum, wait, restore, tap, output
// [RL19] Power-on: init, then stabilise, then load
// [RL20] Prescaler divides by four or two
// [RL21] Prescaler bypass bit skips prescaler
// [RL22] Divider bypass routes master clock directly
// [RL23] Select pin high internal, low external
// [RL24] Stabilisation wait counts 256 master clocks
// [RL25] Synchronise gate, select and power-down pins
`timescale 1ns/1ps
`default_nettype none
module cdes_core (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic internalRefClk,
   input wire logic externalRefClk,
   input wire logic gatePin,
   input wire logic powerDownSelectPin,
   input wire cdes_pkg::cdes_cfg_t storedConfig,
   output logic referenceClockPin,
   output logic referenceClockOe,
   output logic dividedClockPin,
   output logic dividedClockOe,
   output logic internalOscEnable,
   output logic externalBufferEnable,
   output logic stabilizing
);
   logic [cdes_pkg::SYNC_WIDTH-1:0] synced;
   logic intS, extS, gateS, pinS;
   logic intPrev, internal_reference_clock, intClkPrev, intFall, intRise, intRawRise;
   logic [1:0] preCnt;
   cdes_pkg::cdes_cfg_t progCfg, activeCfg;
   cdes_pkg::cdes_mux_t muxState;
   cdes_pkg::cdes_seq_t seqState;
   logic wantExt, pdReq, refLevel, refPrev, masterRise, masterFall, armed;
   logic gateCap, gateForce, running, dividedLevel, bypassRun;
   logic useMax, tapOn, outOn, oscOn, masterStop;
   logic [9:0] cnt, effDivisor, highLen, nextCnt;
   logic [8:0] stabCnt;

   // [RL25] pin synchronisers
   cdes_sync #(.W(cdes_pkg::SYNC_WIDTH)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn({internalRefClk, externalRefClk, gatePin, powerDownSelectPin}),
      .syncOut(synced)
   );
   assign {intS, extS, gateS, pinS} = synced;

   // Settings forced to maximum while the oscillator settles
   always_comb
   begin
      activeCfg = progCfg;
      if (useMax)
      begin
         activeCfg.prescalerBypass = 1'h0;
         activeCfg.prescalerRatio = 1'h0;
         activeCfg.divisorWord = cdes_pkg::DIVISOR_MAX;
      end
   end

   // [RL2] pin function choice; [RL23] select overrides choice bit
   assign wantExt = activeCfg.pinFunction ? activeCfg.referenceChoice : !pinS;
   // [RL15] low pin requests power-down
   assign pdReq = activeCfg.pinFunction && !pinS;

   // [RL20] prescaler counts internal oscillator rises
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         intPrev <= 1'h0;
         preCnt <= 2'h0;
      end
      else
      begin
         intPrev <= intS;
         if (intRawRise)
            preCnt <= preCnt + 2'h1;
      end
   end
   assign intRawRise = intS && !intPrev;
   // [RL21] bypass skips the prescaler; ratio bit 1 halves, 0 quarters
   assign internal_reference_clock = activeCfg.prescalerBypass ? intS
                 : (activeCfg.prescalerRatio ? preCnt[0] : preCnt[1]);

   // Edge history of internal clock and master clock
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         intClkPrev <= 1'h0;
         refPrev <= 1'h0;
      end
      else
      begin
         intClkPrev <= internal_reference_clock;
         refPrev <= refLevel;
      end
   end
   assign intFall = !internal_reference_clock && intClkPrev;
   assign intRise = internal_reference_clock && !intClkPrev;
   assign masterRise = refLevel && !refPrev;
   assign masterFall = !refLevel && refPrev;

   // Glitch-free reference mux; output held low across each switch
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         muxState <= cdes_pkg::MX_INT;
         refLevel <= 1'h0;
         armed <= 1'h0;
      end
      else if (masterStop)
         refLevel <= 1'h0;
      else
      begin
         case (muxState)
            cdes_pkg::MX_INT:
            begin
               refLevel <= internal_reference_clock;
               armed <= 1'h0;
               // [RL10] request seen on internal falling edge
               if (wantExt && intFall)
               begin
                  muxState <= cdes_pkg::MX_TO_EXT;
                  refLevel <= 1'h0;
               end
            end
            cdes_pkg::MX_TO_EXT:
            begin
               refLevel <= 1'h0;
               // Next internal rise marks at least half a period of low hold
               if (intRise)
                  armed <= 1'h1;
               // [RL11] wait for external low before routing
               if (armed && !extS)
               begin
                  muxState <= cdes_pkg::MX_EXT;
                  armed <= 1'h0;
               end
            end
            cdes_pkg::MX_EXT:
            begin
               refLevel <= extS;
               // [RL12] level triggered; stuck-high external blocks it
               if (!wantExt && !extS)
               begin
                  muxState <= cdes_pkg::MX_TO_INT;
                  refLevel <= 1'h0;
               end
            end
            cdes_pkg::MX_TO_INT:
            begin
               refLevel <= 1'h0;
               // [RL13] low until internal fall, then pass next rise
               if (intFall)
                  armed <= 1'h1;
               if (armed && intRise)
               begin
                  muxState <= cdes_pkg::MX_INT;
                  refLevel <= 1'h1;
                  armed <= 1'h0;
               end
            end
            default:
               muxState <= cdes_pkg::MX_INT;
         endcase
      end
   end

   // [RL1] divisor is the field plus two
   assign effDivisor = {1'h0, activeCfg.divisorWord} + cdes_pkg::DIVISOR_BIAS;
   assign highLen = effDivisor >> 1;
   assign nextCnt = (cnt == effDivisor - 10'h001) ? 10'h000 : cnt + 10'h001;

   // [RL5] gate sampled on master rise; [RL6] late edge waits a cycle
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         gateCap <= 1'h0;
      else if (masterRise)
         gateCap <= gateS && !gateForce;
   end

   // Programmable divider with synchronous gating
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt <= 10'h000;
         running <= 1'h0;
         dividedLevel <= 1'h0;
      end
      else if (masterRise)
      begin
         if (!running)
         begin
            cnt <= 10'h000;
            running <= gateCap;
            dividedLevel <= gateCap;
         end
         // [RL7] stop only once the high pulse has ended
         // [RL8] gate missed while low lets another pulse out
         else if (!gateCap && nextCnt >= highLen)
         begin
            running <= 1'h0;
            cnt <= 10'h000;
            dividedLevel <= 1'h0;
         end
         else
         begin
            cnt <= nextCnt;
            dividedLevel <= nextCnt < highLen;
         end
      end
   end

   // [RL9] divide-by-one gating changes on master fall only
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         bypassRun <= 1'h0;
      else if (masterFall)
         bypassRun <= gateCap;
   end

   // Enabling sequencer: power-on, power-down and power-up ordering
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         // [RL19] power-on starts in the stabilisation wait
         seqState <= cdes_pkg::SQ_STAB;
         stabCnt <= 9'h000;
         useMax <= 1'h1;
         tapOn <= 1'h0;
         outOn <= 1'h0;
         oscOn <= 1'h1;
         // Gate refused until the wait ends, so a shrinking divisor never strands the count
         gateForce <= 1'h1;
         masterStop <= 1'h0;
         progCfg <= cdes_pkg::CFG_DEFAULT;
      end
      else
      begin
         case (seqState)
            cdes_pkg::SQ_STAB:
            begin
               // [RL24] count master clocks with maxed settings
               if (masterRise)
                  stabCnt <= stabCnt + 9'h001;
               // [RL18] restore programmed values after the wait
               if (masterRise && stabCnt == cdes_pkg::STAB_CYCLES - 9'h001)
               begin
                  progCfg <= storedConfig;
                  useMax <= 1'h0;
                  gateForce <= 1'h0;
                  seqState <= cdes_pkg::SQ_OUT_EN;
               end
            end
            cdes_pkg::SQ_OUT_EN:
            begin
               // Tap enabled first, divided output one cycle later
               tapOn <= 1'h1;
               seqState <= cdes_pkg::SQ_RUN;
            end
            cdes_pkg::SQ_RUN:
            begin
               outOn <= 1'h1;
               if (pdReq)
               begin
                  gateForce <= 1'h1;
                  seqState <= cdes_pkg::SQ_GATE_OFF;
               end
            end
            cdes_pkg::SQ_GATE_OFF:
               // [RL16] float divided output once it is low
               if (!running && !dividedLevel && !bypassRun && !dividedClockPin)
               begin
                  outOn <= 1'h0;
                  seqState <= cdes_pkg::SQ_TAP_OFF;
               end
            cdes_pkg::SQ_TAP_OFF:
               // [RL4] tap stops glitch-free with the master clock
               if (!refLevel)
               begin
                  masterStop <= 1'h1;
                  tapOn <= 1'h0;
                  seqState <= cdes_pkg::SQ_OSC_OFF;
               end
            cdes_pkg::SQ_OSC_OFF:
            begin
               // [RL17] oscillator and buffer go last
               oscOn <= 1'h0;
               seqState <= cdes_pkg::SQ_DOWN;
            end
            cdes_pkg::SQ_DOWN:
               if (!pdReq)
               begin
                  oscOn <= 1'h1;
                  masterStop <= 1'h0;
                  useMax <= 1'h1;
                  stabCnt <= 9'h000;
                  seqState <= cdes_pkg::SQ_STAB;
               end
            default:
               seqState <= cdes_pkg::SQ_STAB;
         endcase
      end
   end

   // Registered pins; [RL3] tap disable bit floats the reference pin
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         referenceClockPin <= 1'h0;
         referenceClockOe <= 1'h0;
         dividedClockPin <= 1'h0;
         dividedClockOe <= 1'h0;
         internalOscEnable <= 1'h0;
         externalBufferEnable <= 1'h0;
         stabilizing <= 1'h1;
      end
      else
      begin
         referenceClockPin <= refLevel && tapOn && !activeCfg.referenceTapDisable;
         referenceClockOe <= tapOn && !activeCfg.referenceTapDisable;
         // [RL22] divider bypass passes master clock; [RL14] same switching
         dividedClockPin <= outOn && (activeCfg.bypassDivisor ? (refLevel && bypassRun)
                                                               : dividedLevel);
         dividedClockOe <= outOn;
         internalOscEnable <= oscOn;
         externalBufferEnable <= oscOn;
         stabilizing <= seqState == cdes_pkg::SQ_STAB;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   div_range_a: assert property (running |-> cnt < effDivisor) // [RL1]
      else $error("divider count beyond divisor");
   tap_disable_a: assert property ($past(activeCfg.referenceTapDisable) |-> !referenceClockOe) // [RL3]
      else $error("reference pin driven while disabled");
   gate_start_a: assert property ( // [RL5]
      (masterRise && gateCap && !running) |=> running && dividedLevel ##1 dividedClockPin || !outOn)
      else $error("divided output did not start after gate");
   no_trunc_a: assert property ($fell(running) |-> !dividedLevel && $past(cnt) >= $past(highLen) - 10'h001) // [RL7]
      else $error("divided pulse truncated");
   ext_low_a: assert property ( // [RL11]
      (muxState == cdes_pkg::MX_TO_EXT) ##1 (muxState == cdes_pkg::MX_EXT) |-> $past(!extS))
      else $error("external routed while high");
   int_rise_a: assert property ( // [RL13]
      (muxState == cdes_pkg::MX_TO_INT) ##1 (muxState == cdes_pkg::MX_INT) |-> refLevel)
      else $error("internal not passed on a rise");
   pd_order_a: assert property ($fell(tapOn) |-> !outOn && !dividedClockOe) // [RL16]
      else $error("tap stopped before divided output");
   osc_last_a: assert property ($fell(internalOscEnable) |-> !referenceClockOe && !dividedClockOe) // [RL17]
      else $error("oscillator off while outputs active");
   stab_quiet_a: assert property ((seqState == cdes_pkg::SQ_STAB) |=> !dividedClockOe ##1 !dividedClockOe) // [RL24]
      else $error("output enabled during stabilisation");
endmodule : cdes_core
`default_nettype wire

// ### hdl/cdes_pkg.sv
// Shared types and constants for the clock divider and enable sequencer
package cdes_pkg;
   // Configuration held in non-volatile storage
   typedef struct packed {
      logic referenceTapDisable;
      logic pinFunction;
      logic prescalerRatio;
      logic prescalerBypass;
      logic bypassDivisor;
      logic referenceChoice;
      logic [8:0] divisorWord;
   } cdes_cfg_t;

   typedef enum logic [1:0] {MX_INT, MX_TO_EXT, MX_EXT, MX_TO_INT} cdes_mux_t;
   typedef enum logic [2:0] {
      SQ_STAB, SQ_OUT_EN, SQ_RUN, SQ_GATE_OFF, SQ_TAP_OFF, SQ_OSC_OFF, SQ_DOWN
   } cdes_seq_t;

   localparam int SYNC_STAGES = 2;
   localparam int SYNC_WIDTH = 4;
   localparam logic [9:0] DIVISOR_BIAS = 10'h002;
   localparam logic [8:0] DIVISOR_MAX = 9'h1ff;
   localparam logic [8:0] STAB_CYCLES = 9'h100;
   // Shipped defaults: tap off, power-down function, prescaler bypassed, internal reference
   localparam cdes_cfg_t CFG_DEFAULT = '{
      referenceTapDisable: 1'h1, pinFunction: 1'h1, prescalerRatio: 1'h0,
      prescalerBypass: 1'h1, bypassDivisor: 1'h0, referenceChoice: 1'h0,
      divisorWord: 9'h000};
endpackage : cdes_pkg

// ### hdl/cdes_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module cdes_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         stage1 <= '0;
         syncOut <= '0;
      end
      else
      begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule : cdes_sync
`default_nettype wire
